// ==== design/drsch_tracker.sv ====
// Refresh scheduling tracker for one channel of the memory device
`timescale 1ns/1ps
// Operation
// - After an all-bank refresh the channel is busy 280 ns and takes no command meanwhile.
// - After a per-bank refresh that bank is busy 140 ns and may not be accessed meanwhile.
// - After an aborted self refresh the next command waits the bank cycle time plus 17.5 ns.
// - Per-bank tracking covers all 8 banks of the channel.
module drsch_tracker import drsch_pkg::*; #(
   parameter int unsigned WINDOW_CYC = REFRESH_WINDOW_CYC, // Normal refresh window
   parameter int unsigned INTERVAL_CYC = AVG_REFRESH_INTERVAL_CYC // Average interval
) (
   input wire logic clk_sys, // System clock, 50 MHz
   input wire logic reset, // Synchronous reset, active high
   input wire logic [1:0] rate_sel, // Refresh rate mode
   input wire logic cmd_valid, // Command strobe
   input wire logic cmd_all_ref, // Command is all-bank refresh
   input wire logic cmd_bank_ref, // Command is per-bank refresh
   input wire logic cmd_access, // Command is a bank access
   input wire logic [2:0] cmd_bank, // Target bank
   input wire logic sr_enter, // Self refresh entry strobe
   input wire logic sr_exit, // Self refresh exit strobe
   input wire logic sr_abort, // Exit is an aborted self refresh
   output logic chan_ready, // Channel takes a command now
   output logic [NUM_BANKS-1:0] bank_busy, // Per-bank refresh in progress
   output logic in_self_refresh, // Channel in self refresh
   output logic refresh_due, // Average refresh rate behind
   output logic window_end, // Window boundary pulse
   output logic refresh_short, // Window closed with too few refreshes
   output logic viol_busy, // Command hit a busy channel or bank
   output logic viol_spacing // Per-bank refreshes too close
);

   // ----------------------------------------
   // Command decode
   // ----------------------------------------
   function automatic logic [NUM_BANKS-1:0] bank_onehot(input logic [2:0] b);
      bank_onehot = NUM_BANKS'(1) << b;
   endfunction

   drsch_sr_state_type sr_r;
   drsch_sr_state_type sr_nxt;
   logic all_busy;
   logic exit_busy;
   logic space_busy;
   logic [2:0] last_bank_r;
   logic [2:0] last_bank_nxt;
   logic hit_bank;
   logic bad_busy;
   logic bad_space;
   logic take;
   logic take_all;
   logic take_bank;
   logic exit_load;
   logic [TMR_W-1:0] exit_val;

   assign chan_ready = (sr_r == SR_ACTIVE) && !all_busy && !exit_busy;
   assign hit_bank = |(bank_busy & bank_onehot(cmd_bank));
   // An all-bank refresh needs every bank idle
   assign bad_busy = cmd_valid && (!chan_ready || (cmd_all_ref && (|bank_busy)) ||
                     ((cmd_bank_ref || cmd_access) && hit_bank));
   assign bad_space = cmd_valid && cmd_bank_ref && !cmd_all_ref && space_busy &&
                      (cmd_bank != last_bank_r);
   // Offending commands are refused so they cannot extend busy time
   assign take = cmd_valid && !bad_busy && !bad_space;
   assign take_all = take && cmd_all_ref;
   assign take_bank = take && cmd_bank_ref && !cmd_all_ref;

   // ----------------------------------------
   // Busy timers
   // ----------------------------------------
   drsch_down_timer u_all (
      .clk_sys(clk_sys),
      .reset(reset),
      .load(take_all),
      .load_val(LOAD_ALL),
      .busy(all_busy)
   );

   drsch_down_timer u_space (
      .clk_sys(clk_sys),
      .reset(reset),
      .load(take_bank),
      .load_val(LOAD_SPACING),
      .busy(space_busy)
   );

   // Return to active costs one edge, so the timer runs one short
   assign exit_val = sr_abort ? (LOAD_ABORT - 4'h1) : (LOAD_EXIT - 4'h1);
   assign exit_load = (sr_r == SR_SELF) && sr_exit;

   drsch_down_timer u_exit (
      .clk_sys(clk_sys),
      .reset(reset),
      .load(exit_load),
      .load_val(exit_val),
      .busy(exit_busy)
   );

   genvar gi;
   generate
      for (gi = 0; gi < NUM_BANKS; gi++) begin : g_bank
         drsch_down_timer u_bank (
            .clk_sys(clk_sys),
            .reset(reset),
            .load(take_bank && (cmd_bank == 3'(gi))),
            .load_val(LOAD_BANK),
            .busy(bank_busy[gi])
         );
      end
   endgenerate

   // ----------------------------------------
   // Self refresh state
   // ----------------------------------------
   always_comb begin
      sr_nxt = sr_r;
      last_bank_nxt = take_bank ? cmd_bank : last_bank_r;
      case (sr_r)
         SR_ACTIVE: begin
            if (sr_enter && chan_ready && (bank_busy == '0)) begin
               sr_nxt = SR_SELF;
            end
         end
         SR_SELF: begin
            if (sr_exit) begin
               sr_nxt = SR_EXIT;
            end
         end
         SR_EXIT: begin
            // Exit timer loaded on the edge that enters this state, so already busy here
            if (!exit_busy) begin
               sr_nxt = SR_ACTIVE;
            end
         end
         default: begin
            sr_nxt = SR_ACTIVE;
         end
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         sr_r <= SR_ACTIVE;
         last_bank_r <= 3'h0;
      end else begin
         sr_r <= sr_nxt;
         last_bank_r <= last_bank_nxt;
      end
   end

   assign in_self_refresh = (sr_r != SR_ACTIVE);

   // ----------------------------------------
   // Window and average rate bookkeeping
   // ----------------------------------------
   logic [WIN_W-1:0] win_cnt_r;
   logic [WIN_W-1:0] win_cnt_nxt;
   logic [WIN_W-1:0] win_last;
   logic [IVL_W-1:0] ivl_cnt_r;
   logic [IVL_W-1:0] ivl_cnt_nxt;
   logic [REFCNT_W-1:0] ref_cnt_r;
   logic [REFCNT_W-1:0] ref_cnt_nxt;
   logic [DEBT_W-1:0] debt_r;
   logic [DEBT_W-1:0] debt_nxt;
   logic win_tick;
   logic ivl_tick;
   logic window_end_r;
   logic refresh_short_r;
   logic viol_busy_r;
   logic viol_spacing_r;
   logic [DEBT_W-1:0] debt_add;
   logic [DEBT_W-1:0] debt_sub;

   always_comb begin
      case (rate_sel)
         RATE_HALF: win_last = WIN_W'((WINDOW_CYC >> 1) - 1);
         RATE_QUARTER: win_last = WIN_W'((WINDOW_CYC >> 2) - 1);
         default: win_last = WIN_W'(WINDOW_CYC - 1);
      endcase
   end

   assign win_tick = (win_cnt_r >= win_last);
   assign ivl_tick = (ivl_cnt_r == IVL_W'(INTERVAL_CYC - 1));
   // Self refresh keeps the array alive internally, so no debt builds up
   assign debt_add = (ivl_tick && (sr_r == SR_ACTIVE)) ? DEBT_ALL : 8'h00;
   assign debt_sub = take_all ? DEBT_ALL : (take_bank ? DEBT_BANK : 8'h00);

   always_comb begin
      win_cnt_nxt = win_tick ? '0 : win_cnt_r + 21'h1;
      ivl_cnt_nxt = ivl_tick ? '0 : ivl_cnt_r + 18'h1;
      ref_cnt_nxt = ref_cnt_r;
      if (take_all || take_bank) begin
         ref_cnt_nxt = (ref_cnt_r == REFCNT_MIN) ? ref_cnt_r : ref_cnt_r + 14'h1;
      end
      if (win_tick) begin
         // A refresh in the boundary cycle counts toward the new window
         ref_cnt_nxt = (take_all || take_bank) ? 14'h1 : 14'h0;
      end
      if (debt_r > DEBT_MAX - debt_add) begin
         debt_nxt = DEBT_MAX;
      end else begin
         debt_nxt = debt_r + debt_add;
      end
      debt_nxt = (debt_nxt > debt_sub) ? debt_nxt - debt_sub : 8'h00;
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         win_cnt_r <= '0;
         ivl_cnt_r <= '0;
         ref_cnt_r <= '0;
         debt_r <= 8'h00;
         window_end_r <= 1'b0;
         refresh_short_r <= 1'b0;
         viol_busy_r <= 1'b0;
         viol_spacing_r <= 1'b0;
      end else begin
         win_cnt_r <= win_cnt_nxt;
         ivl_cnt_r <= ivl_cnt_nxt;
         ref_cnt_r <= ref_cnt_nxt;
         debt_r <= debt_nxt;
         window_end_r <= win_tick;
         refresh_short_r <= win_tick && (ref_cnt_r < REFCNT_MIN);
         viol_busy_r <= bad_busy;
         viol_spacing_r <= bad_space && !bad_busy;
      end
   end

   assign refresh_due = (debt_r >= DEBT_ALL);
   assign window_end = window_end_r;
   assign refresh_short = refresh_short_r;
   assign viol_busy = viol_busy_r;
   assign viol_spacing = viol_spacing_r;

endmodule

// ==== design/drsch_pkg.sv ====
// Constants and types shared by the refresh scheduling tracker
package drsch_pkg;

   // ----------------------------------------
   // Clock
   // ----------------------------------------
   localparam int unsigned CLK_MHZ = 50;
   localparam int unsigned PS_PER_US = 1000000;

   // ----------------------------------------
   // Refresh timing, as printed
   // ----------------------------------------
   localparam int unsigned REFRESH_CYCLE_ALL_PS = 280000;
   localparam int unsigned REFRESH_CYCLE_BANK_PS = 140000;
   localparam int unsigned BANK_REFRESH_SPACING_PS = 90000;
   localparam int unsigned ABORT_EXIT_EXTRA_PS = 17500;
   localparam int unsigned EXIT_EXTRA_PS = 7500;
   localparam int unsigned EXIT_MIN_CK = 2;
   localparam int unsigned REFRESH_WINDOW_MS = 32;
   localparam int unsigned AVG_REFRESH_INTERVAL_US = 3904;
   localparam int unsigned MIN_REFRESH_CMDS = 8192;
   localparam int unsigned NUM_BANKS = 8;

   // ----------------------------------------
   // Derived cycle counts (least times round up)
   // ----------------------------------------
   localparam int unsigned REFRESH_CYCLE_ALL_CYC =
      (REFRESH_CYCLE_ALL_PS * CLK_MHZ + PS_PER_US - 1) / PS_PER_US;
   localparam int unsigned REFRESH_CYCLE_BANK_CYC =
      (REFRESH_CYCLE_BANK_PS * CLK_MHZ + PS_PER_US - 1) / PS_PER_US;
   localparam int unsigned BANK_REFRESH_SPACING_CYC =
      (BANK_REFRESH_SPACING_PS * CLK_MHZ + PS_PER_US - 1) / PS_PER_US;
   localparam int unsigned ABORTED_EXIT_CYC =
      ((REFRESH_CYCLE_BANK_PS + ABORT_EXIT_EXTRA_PS) * CLK_MHZ + PS_PER_US - 1) / PS_PER_US;
   localparam int unsigned EXIT_NS_CYC =
      ((REFRESH_CYCLE_ALL_PS + EXIT_EXTRA_PS) * CLK_MHZ + PS_PER_US - 1) / PS_PER_US;
   localparam int unsigned SELF_REFRESH_EXIT_CYC =
      (EXIT_NS_CYC > EXIT_MIN_CK) ? EXIT_NS_CYC : EXIT_MIN_CK;
   localparam int unsigned REFRESH_WINDOW_CYC = REFRESH_WINDOW_MS * CLK_MHZ * 1000;
   localparam int unsigned AVG_REFRESH_INTERVAL_CYC = AVG_REFRESH_INTERVAL_US * CLK_MHZ;

   // ----------------------------------------
   // Widths and timer loads
   // ----------------------------------------
   localparam int unsigned TMR_W = 4;
   localparam int unsigned WIN_W = 21;
   localparam int unsigned IVL_W = 18;
   localparam int unsigned REFCNT_W = 14;
   localparam int unsigned DEBT_W = 8;
   localparam logic [TMR_W-1:0] LOAD_ALL = TMR_W'(REFRESH_CYCLE_ALL_CYC - 1);
   localparam logic [TMR_W-1:0] LOAD_BANK = TMR_W'(REFRESH_CYCLE_BANK_CYC - 1);
   localparam logic [TMR_W-1:0] LOAD_SPACING = TMR_W'(BANK_REFRESH_SPACING_CYC - 1);
   localparam logic [TMR_W-1:0] LOAD_EXIT = TMR_W'(SELF_REFRESH_EXIT_CYC - 1);
   localparam logic [TMR_W-1:0] LOAD_ABORT = TMR_W'(ABORTED_EXIT_CYC - 1);
   localparam logic [TMR_W-1:0] TMR_ZERO = 4'h0;
   localparam logic [REFCNT_W-1:0] REFCNT_MIN = REFCNT_W'(MIN_REFRESH_CMDS);
   localparam logic [DEBT_W-1:0] DEBT_ALL = 8'h08;
   localparam logic [DEBT_W-1:0] DEBT_BANK = 8'h01;
   localparam logic [DEBT_W-1:0] DEBT_MAX = 8'hff;

   // ----------------------------------------
   // Modes and states
   // ----------------------------------------
   typedef enum logic [1:0] {
      RATE_NORMAL = 2'h0,
      RATE_HALF = 2'h1,
      RATE_QUARTER = 2'h2
   } drsch_rate_type;

   typedef enum logic [1:0] {
      SR_ACTIVE = 2'h0,
      SR_SELF = 2'h1,
      SR_EXIT = 2'h3
   } drsch_sr_state_type;

endpackage

// ==== design/drsch_down_timer.sv ====
// Loadable down counter that marks a busy interval
`timescale 1ns/1ps
module drsch_down_timer import drsch_pkg::*; (
   input wire logic clk_sys, // System clock
   input wire logic reset, // Synchronous reset
   input wire logic load, // Start interval
   input wire logic [TMR_W-1:0] load_val, // Busy cycles after load
   output logic busy // Interval running
);

   logic [TMR_W-1:0] cnt_r;
   logic [TMR_W-1:0] cnt_nxt;

   always_comb begin
      cnt_nxt = cnt_r;
      if (load) begin
         cnt_nxt = load_val;
      end else if (cnt_r != TMR_ZERO) begin
         cnt_nxt = cnt_r - 4'h1;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         cnt_r <= TMR_ZERO;
      end else begin
         cnt_r <= cnt_nxt;
      end
   end

   assign busy = (cnt_r != TMR_ZERO);

endmodule

// ==== dv/drsch_tracker_chk.sv ====
// Port assertions for the refresh tracker
`timescale 1ns/1ps
module drsch_tracker_chk import drsch_pkg::*; #(
   parameter int unsigned WINDOW_CYC = 64, // Window
   parameter int unsigned INTERVAL_CYC = 16 // Interval
) (
   input wire logic clk_sys, // Clock
   input wire logic reset, // Reset
   input wire logic [1:0] rate_sel, // Rate
   input wire logic cmd_valid, // Strobe
   input wire logic cmd_all_ref, // All-bank
   input wire logic cmd_bank_ref, // Per-bank
   input wire logic cmd_access, // Access
   input wire logic [2:0] cmd_bank, // Bank
   input wire logic sr_enter, // Entry
   input wire logic sr_exit, // Exit
   input wire logic sr_abort, // Abort
   input wire logic chan_ready, // Ready
   input wire logic [NUM_BANKS-1:0] bank_busy, // Busy banks
   input wire logic in_self_refresh, // Self refresh
   input wire logic refresh_due, // Due
   input wire logic window_end, // Window pulse
   input wire logic refresh_short, // Short
   input wire logic viol_busy, // Busy hit
   input wire logic viol_spacing // Spacing hit
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (reset);
   logic exit_seen_r;
   // Later exit strobes in the same self refresh are ignored by the design
   always_ff @(posedge clk_sys) begin
      if (reset || !in_self_refresh) begin
         exit_seen_r <= 1'b0;
      end else if (sr_exit) begin
         exit_seen_r <= 1'b1;
      end
   end
   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   a_all_busy_span: assert property (
      cmd_valid && cmd_all_ref && chan_ready && bank_busy == '0
      |=> !chan_ready [*8] ##1 !chan_ready [*5] ##1 chan_ready) else $error("all-bank span");
   a_chan_busy_flag: assert property (
      cmd_valid && !chan_ready |=> viol_busy) else $error("busy channel not flagged");
   a_bank_busy_flag: assert property (
      cmd_valid && !cmd_all_ref && (cmd_bank_ref || cmd_access) && bank_busy[cmd_bank]
      |=> viol_busy) else $error("busy bank not flagged");
   for (genvar b = 0; b < NUM_BANKS; b++) begin : g_bank
      a_bank_span: assert property (
         $rose(bank_busy[b]) |-> bank_busy[b] [*6] ##1 !bank_busy[b]) else $error("bank span");
      a_bank_cause: assert property (
         $rose(bank_busy[b]) |-> $past(cmd_valid && cmd_bank_ref && cmd_bank == 3'(b)))
         else $error("bank busy without refresh");
   end
   a_abort_wait: assert property (
      sr_exit && sr_abort && in_self_refresh && !chan_ready && !exit_seen_r
      |=> !chan_ready [*7] ##1 chan_ready) else $error("aborted exit delay");
   a_exit_source: assert property (
      $rose(chan_ready) && $past(in_self_refresh)
      |-> $past(sr_exit && sr_abort, 8) || $past(sr_exit && !sr_abort, 15))
      else $error("exit delay");
   a_window_pulse: assert property (
      window_end |=> !window_end) else $error("window pulse too long");
   c_all_ref: cover property (cmd_valid && cmd_all_ref && chan_ready);
   c_abort: cover property (sr_exit && sr_abort && in_self_refresh);
   c_short: cover property (refresh_short);
endmodule
bind drsch_tracker drsch_tracker_chk #(.WINDOW_CYC(WINDOW_CYC), .INTERVAL_CYC(INTERVAL_CYC))
   u_chk (.*);

// ==== dv/drsch_ctrl_model.sv ====
// Memory controller model issuing refresh and access commands
`timescale 1ns/1ps
module drsch_ctrl_model import drsch_pkg::*; (
   input wire logic clk_sys, // Clock
   input wire logic req, // Request pulse
   input wire logic [1:0] op, // 0 plain 1 all 2 bank 3 access
   input wire logic [2:0] bank, // Bank
   input wire logic polite, // Keep timing
   input wire logic chan_ready, // Ready
   input wire logic [NUM_BANKS-1:0] bank_busy, // Busy banks
   output logic cmd_valid, // Strobe
   output logic cmd_all_ref, // All-bank
   output logic cmd_bank_ref, // Per-bank
   output logic cmd_access, // Access
   output logic [2:0] cmd_bank, // Bank
   output logic issued // Command on bus
);
   logic pend = 1'b0;
   logic ok;
   // Spacing history belongs to this channel only
   logic [2:0] last = 3'h0;
   int gap = 0;
   initial {cmd_valid, cmd_all_ref, cmd_bank_ref, cmd_access, cmd_bank, issued} = '0;
   always @(negedge clk_sys) begin
      ok = chan_ready && !(op == 2'h1 && bank_busy != '0)
         && (op < 2'h2 || !bank_busy[bank])
         && !(op == 2'h2 && bank != last && gap < BANK_REFRESH_SPACING_CYC);
      if (req) pend = 1'b1;
      gap = gap + 1;
      if (pend && (!polite || ok)) begin
         pend = 1'b0;
         {cmd_valid, issued, cmd_bank} <= {2'b11, bank};
         {cmd_all_ref, cmd_bank_ref, cmd_access} <= {op == 2'h1, op == 2'h2, op == 2'h3};
         if (op == 2'h2) begin
            gap = 0;
            last = bank;
         end
      end else begin
         // Unqualified lines wander so idle values are never trusted
         {cmd_valid, issued} <= 2'b00;
         {cmd_all_ref, cmd_bank_ref, cmd_access} <= ~{cmd_all_ref, cmd_bank_ref, cmd_access};
         cmd_bank <= ~cmd_bank;
      end
   end
endmodule

// ==== dv/tb.sv ====
// Self-checking bench for the refresh tracker
`timescale 1ns/1ps
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin mismatches++; \
   $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, (a), (e)); end end
module tb import drsch_pkg::*; ;
   typedef struct {logic [1:0] op; logic [2:0] bank; logic polite, vb, vs;} drsch_row_type;
   logic clk_sys = 1'b0, reset = 1'b1, req = 1'b0, polite = 1'b0;
   logic sr_enter = 1'b0, sr_exit = 1'b0, sr_abort = 1'b0;
   logic [1:0] rate_sel = 2'h0, op = 2'h0;
   logic [2:0] bank = 3'h0, cmd_bank;
   logic cmd_valid, cmd_all_ref, cmd_bank_ref, cmd_access, issued, chan_ready;
   logic in_self_refresh, refresh_due, window_end, refresh_short, viol_busy, viol_spacing;
   logic [NUM_BANKS-1:0] bank_busy;
   int mismatches = 0, compares = 0, k, n;
   drsch_row_type rows [9] = '{'{2'h1, 3'h0, 1, 0, 0}, '{2'h3, 3'h0, 0, 1, 0},
      '{2'h0, 3'h0, 1, 0, 0}, '{2'h2, 3'h3, 1, 0, 0}, '{2'h3, 3'h3, 0, 1, 0},
      '{2'h2, 3'h4, 0, 0, 1}, '{2'h2, 3'h4, 1, 0, 0}, '{2'h1, 3'h0, 0, 1, 0},
      '{2'h3, 3'h3, 1, 0, 0}};
   always #10 clk_sys = ~clk_sys;
   drsch_tracker #(.WINDOW_CYC(64), .INTERVAL_CYC(16)) u_dut (.*);
   drsch_ctrl_model u_ctrl (.*);
   task automatic wrap_up;
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic cmd(input logic [1:0] o, input logic [2:0] b, input logic p);
      @(negedge clk_sys);
      {op, bank, polite, req} <= {o, b, p, 1'b1};
      @(negedge clk_sys);
      req <= 1'b0;
      k = 0;
      do begin @(posedge clk_sys); k++; end while (issued !== 1'b1 && k < 60);
      if (k >= 60) mismatches++;
      #1;
   endtask
   task automatic wait_ready;
      n = 1;
      while (chan_ready !== 1'b1 && n < 40) begin @(posedge clk_sys); #1; n++; end
   endtask
   task automatic do_reset;
      @(negedge clk_sys) reset <= 1'b1;
      @(negedge clk_sys) reset <= 1'b0;
      `CHK({chan_ready, bank_busy, in_self_refresh, refresh_due}, 11'h400)
      $display("test reset done");
   endtask
   initial begin
      #100000;
      mismatches++;
      wrap_up();
   end
   initial begin
      do_reset();
      for (int i = 0; i < 9; i++) begin
         cmd(rows[i].op, rows[i].bank, rows[i].polite);
         `CHK(viol_busy, rows[i].vb)
         `CHK(viol_spacing, rows[i].vs)
      end
      $display("test rows done");
      repeat (20) @(posedge clk_sys);
      for (int b = 0; b < NUM_BANKS; b++) begin
         cmd(2'h2, 3'(b), 1'b1);
         n = 1;
         while (bank_busy[b] === 1'b1 && n < 20) begin @(posedge clk_sys); #1; n++; end
         `CHK(n, 7)
      end
      $display("test banks done");
      for (int a = 0; a < 2; a++) begin
         repeat (8) @(posedge clk_sys);
         @(negedge clk_sys) sr_enter <= 1'b1;
         @(negedge clk_sys) sr_enter <= 1'b0;
         `CHK(in_self_refresh, 1'b1)
         cmd(2'h0, 3'h0, 1'b0);
         `CHK(viol_busy, 1'b1)
         @(negedge clk_sys) {sr_exit, sr_abort} <= {1'b1, a[0]};
         @(negedge clk_sys) sr_exit <= 1'b0;
         wait_ready();
         `CHK(n, a ? 8 : 15)
         `CHK(in_self_refresh, 1'b0)
      end
      $display("test self refresh done");
      // Code 3 decodes as the normal rate
      for (int r = 0; r < 4; r++) begin
         @(negedge clk_sys) rate_sel <= 2'(r);
         n = 0;
         do begin @(posedge clk_sys); #1; n++; end while (window_end !== 1'b1 && n < 200);
         n = 0;
         do begin @(posedge clk_sys); #1; n++; end while (window_end !== 1'b1 && n < 200);
         `CHK(n, 64 >> (r % 3))
         `CHK(refresh_short, 1'b1)
      end
      $display("test windows done");
      do_reset();
      repeat (20) @(posedge clk_sys);
      #1;
      `CHK(refresh_due, 1'b1)
      cmd(2'h1, 3'h0, 1'b1);
      @(posedge clk_sys);
      #1;
      `CHK(refresh_due, 1'b0)
      wait_ready();
      // One busy edge already spent on the debt check
      `CHK(n, REFRESH_CYCLE_ALL_CYC - 1)
      $display("test debt done");
      wrap_up();
   end
endmodule
